// [rtl/pef_port_edge_irq.sv]
// Top of the sixteen pin port with edge interrupts and glitch filters.
// Assumes mode inputs come from logic on the same bus clock.
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pef_port_edge_irq
(
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Register port.
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Power mode from the system.
  input wire logic stop_mode_in,
  input wire logic wait_mode_in,
  // Port pins.
  input wire logic [15:0] pad_in,
  output logic [15:0] pad_out,
  output logic [15:0] pad_oe_n_out,
  // Interrupts and wake up.
  output logic port_irq_out,
  output logic irq_out,
  output logic wake_out,
  output logic rc_run_out
);

  // Software visible state.
  logic [15:0] pin_irq_enable_r;
  logic [15:0] edge_polarity_select_r;
  logic [15:0] pin_irq_pending_r;
  logic [15:0] pin_irq_pending_nxt;
  logic [15:0] digital_input_enable_r;
  logic [15:0] dir_r;
  logic [15:0] dout_r;
  logic [1:0] stat_r;
  logic [1:0] stat_nxt;
  logic [1:0] mask_r;
  logic analog_en_r;

  // Internal state.
  pef_pkg::pef_mode_t mode_r;
  logic [15:0] pad_meta_r;
  logic [15:0] pad_sync_r;
  logic [7:0] rc_div_r;
  logic rc_tick_r;
  logic rc_run_r;
  logic port_irq_r;
  logic irq_r;
  logic wake_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_val;
  logic [15:0] pad_out_r;
  logic [15:0] pad_oe_n_r;

  // Combinational helpers.
  logic sample_en;
  logic [15:0] din;
  logic [15:0] edge_v;
  logic [15:0] cnt_ok_v;
  logic [15:0] w1c;
  logic rc_cond;
  logic wake_cond;
  logic wr_hit_pend;
  logic rd_hit_stat;

  assign wr_hit_pend = reg_wr_in && reg_addr_in == pef_pkg::OFS_PEND;
  assign rd_hit_stat = reg_rd_in && reg_addr_in == pef_pkg::OFS_STAT;

  // Writable configuration registers.
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_irq_enable_r <= pef_pkg::RST_PINS;
      edge_polarity_select_r <= pef_pkg::RST_PINS;
      digital_input_enable_r <= pef_pkg::RST_PINS;
      dir_r <= pef_pkg::RST_PINS;
      dout_r <= pef_pkg::RST_PINS;
      mask_r <= pef_pkg::RST_STAT;
      analog_en_r <= pef_pkg::RST_ANA;
    end
    else if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        pef_pkg::OFS_IRQ_EN: pin_irq_enable_r <= reg_wdata_in[15:0];
        pef_pkg::OFS_POL: edge_polarity_select_r <= reg_wdata_in[15:0];
        pef_pkg::OFS_DIEN: digital_input_enable_r <= reg_wdata_in[15:0];
        pef_pkg::OFS_DIR: dir_r <= reg_wdata_in[15:0];
        pef_pkg::OFS_DOUT: dout_r <= reg_wdata_in[15:0];
        pef_pkg::OFS_MASK: mask_r <= reg_wdata_in[1:0];
        pef_pkg::OFS_ANA: analog_en_r <= reg_wdata_in[0];
        default: ;
      endcase
    end
  end

  // Pins come from outside the clock domain, so two flops first.
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pad_meta_r <= pef_pkg::RST_PINS;
      pad_sync_r <= pef_pkg::RST_PINS;
    end
    else
    begin
      pad_meta_r <= pad_in;
      pad_sync_r <= pad_meta_r;
    end
  end

  // An enabled analog module forces the digital input high.
  assign din = analog_en_r ? 16'hffff : pad_sync_r;

  // Power mode register; stop wins when both requests are seen.
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      mode_r <= pef_pkg::PEF_RUN;
    else if (stop_mode_in)
      mode_r <= pef_pkg::PEF_STOP;
    else if (wait_mode_in)
      mode_r <= pef_pkg::PEF_WAIT;
    else
      mode_r <= pef_pkg::PEF_RUN;
  end

  // Sample pacing: bus clock in run and wait, oscillator tick in stop.
  always_comb
  begin
    sample_en = 1'b0;
    unique case (mode_r)
      pef_pkg::PEF_RUN: sample_en = 1'b1;
      pef_pkg::PEF_WAIT: sample_en = 1'b1;
      pef_pkg::PEF_STOP: sample_en = rc_tick_r;
      default: sample_en = 1'b0;
    endcase
  end

  // One filter per pin; a pin takes part only as output or enabled input.
  genvar g;
  generate
    for (g = 0; g < pef_pkg::NPINS; g = g + 1)
    begin : g_pin
      pef_filt_if fif ();
      assign fif.sample = sample_en;
      // Select one watches rising edges, zero watches falling edges.
      assign fif.act = edge_polarity_select_r[g] ? din[g] : ~din[g];
      assign fif.clr = ~pin_irq_enable_r[g] |
                       ~(dir_r[g] | digital_input_enable_r[g]);
      assign edge_v[g] = fif.edge_p;
      assign cnt_ok_v[g] = fif.count <= pef_pkg::RC_CNT_LIMIT;
      pef_pin_filter u_filter
      (
        .clk_in(ref_clk_in),
        .rst_in(rst_in),
        .f(fif)
      );
    end
  endgenerate

  // Pending flags: an edge in the clearing cycle still sets the flag.
  assign w1c = wr_hit_pend ? reg_wdata_in[15:0] : 16'h0000;
  assign pin_irq_pending_nxt = (pin_irq_pending_r & ~w1c) | edge_v;

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      pin_irq_pending_r <= pef_pkg::RST_PINS;
    else
      pin_irq_pending_r <= pin_irq_pending_nxt;
  end

  // Shared request, the OR of every enabled pending pin.
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      port_irq_r <= 1'b0;
    else
      port_irq_r <= |(pin_irq_pending_r & pin_irq_enable_r);
  end

  // The oscillator only burns current while some pin may still fire.
  assign rc_cond = mode_r == pef_pkg::PEF_STOP &&
                   |(cnt_ok_v & pin_irq_enable_r & ~pin_irq_pending_r);

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      rc_run_r <= 1'b0;
    else
      rc_run_r <= rc_cond;
  end

  // Oscillator period counter; it restarts from zero on every start.
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rc_div_r <= 8'h00;
      rc_tick_r <= 1'b0;
    end
    else if (!rc_run_r)
    begin
      rc_div_r <= 8'h00;
      rc_tick_r <= 1'b0;
    end
    else if (rc_div_r == pef_pkg::RC_DIV_LAST)
    begin
      rc_div_r <= 8'h00;
      rc_tick_r <= 1'b1;
    end
    else
    begin
      rc_div_r <= rc_div_r + 8'h01;
      rc_tick_r <= 1'b0;
    end
  end

  // Wake up outside run mode; it does not wait for a bus access.
  assign wake_cond = mode_r != pef_pkg::PEF_RUN &&
                     |(pin_irq_pending_nxt & pin_irq_enable_r);

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      wake_r <= 1'b0;
    else
      wake_r <= wake_cond;
  end

  // Sticky event status, cleared by a read; a new event wins the clear.
  always_comb
  begin
    stat_nxt = rd_hit_stat ? 2'h0 : stat_r;
    if (|edge_v)
      stat_nxt[pef_pkg::STAT_EDGE_BIT] = 1'b1;
    if (wake_cond && !wake_r)
      stat_nxt[pef_pkg::STAT_WAKE_BIT] = 1'b1;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stat_r <= pef_pkg::RST_STAT;
      irq_r <= 1'b0;
    end
    else
    begin
      stat_r <= stat_nxt;
      irq_r <= |(stat_r & mask_r);
    end
  end

  // Pad drive; analog use turns the digital output driver off.
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pad_out_r <= pef_pkg::RST_PINS;
      pad_oe_n_r <= 16'hffff;
    end
    else
    begin
      pad_out_r <= dout_r;
      pad_oe_n_r <= ~dir_r | {16{analog_en_r}};
    end
  end

  // Read mux; unmapped offsets read as zero.
  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (reg_addr_in)
      pef_pkg::OFS_IRQ_EN: rd_val[15:0] = pin_irq_enable_r;
      pef_pkg::OFS_POL: rd_val[15:0] = edge_polarity_select_r;
      pef_pkg::OFS_PEND: rd_val[15:0] = pin_irq_pending_r;
      pef_pkg::OFS_DIEN: rd_val[15:0] = digital_input_enable_r;
      pef_pkg::OFS_DIR: rd_val[15:0] = dir_r;
      pef_pkg::OFS_DOUT: rd_val[15:0] = dout_r;
      pef_pkg::OFS_PIN: rd_val[15:0] = din;
      pef_pkg::OFS_STAT: rd_val[1:0] = stat_r;
      pef_pkg::OFS_MASK: rd_val[1:0] = mask_r;
      pef_pkg::OFS_ANA: rd_val[0] = analog_en_r;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Read data stand for exactly one cycle after the strobe.
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_r <= 32'h0000_0000;
    else if (reg_rd_in)
      rdata_r <= rd_val;
    else
      rdata_r <= 32'h0000_0000;
  end

  assign reg_rdata_out = rdata_r;
  assign pad_out = pad_out_r;
  assign pad_oe_n_out = pad_oe_n_r;
  assign port_irq_out = port_irq_r;
  assign irq_out = irq_r;
  assign wake_out = wake_r;
  assign rc_run_out = rc_run_r;

  // Checks on the pending flags, the request, filter sampling, the oscillator, wake up and analog use.
  property p_port_irq;
    @(posedge ref_clk_in) disable iff (rst_in)
    |(pin_irq_pending_r & pin_irq_enable_r) |=> port_irq_out;
  endproperty
  a_port_irq: assert property (p_port_irq)
    else $error("Enabled pending pin gave no port request.");

  property p_no_irq;
    @(posedge ref_clk_in) disable iff (rst_in)
    !(|(pin_irq_pending_r & pin_irq_enable_r)) |=> !port_irq_out;
  endproperty
  a_no_irq: assert property (p_no_irq)
    else $error("Port request without an enabled pending pin.");

  property p_edge_sets;
    @(posedge ref_clk_in) disable iff (rst_in)
    edge_v[0] |=> pin_irq_pending_r[0] ##1 port_irq_out || !pin_irq_enable_r[0];
  endproperty
  a_edge_sets: assert property (p_edge_sets)
    else $error("Edge lost or request missing after it.");

  property p_w1c;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_hit_pend && reg_wdata_in[0] && !edge_v[0] |=> !pin_irq_pending_r[0];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("Writing one did not clear the pending flag.");

  property p_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    pin_irq_pending_r[0] && !(wr_hit_pend && reg_wdata_in[0])
    |=> pin_irq_pending_r[0];
  endproperty
  a_hold: assert property (p_hold)
    else $error("Pending flag dropped without a clearing write.");

  property p_run_sample;
    @(posedge ref_clk_in) disable iff (rst_in)
    mode_r != pef_pkg::PEF_STOP |-> sample_en;
  endproperty
  a_run_sample: assert property (p_run_sample)
    else $error("Filter not sampled on a bus clock in run or wait.");

  property p_rc_gate;
    @(posedge ref_clk_in) disable iff (rst_in)
    !rc_run_out |=> !rc_tick_r;
  endproperty
  a_rc_gate: assert property (p_rc_gate)
    else $error("Oscillator tick while the oscillator is off.");

  property p_rc_run;
    @(posedge ref_clk_in) disable iff (rst_in)
    stop_mode_in && |(cnt_ok_v & pin_irq_enable_r & ~pin_irq_pending_r)
    ##1 mode_r == pef_pkg::PEF_STOP &&
    |(cnt_ok_v & pin_irq_enable_r & ~pin_irq_pending_r)
    |=> rc_run_out;
  endproperty
  a_rc_run: assert property (p_rc_run)
    else $error("Oscillator off while an enabled idle pin waits.");

  property p_wake;
    @(posedge ref_clk_in) disable iff (rst_in)
    mode_r == pef_pkg::PEF_STOP && port_irq_out |-> ##[0:1] wake_out;
  endproperty
  a_wake: assert property (p_wake)
    else $error("Port request in stop mode gave no wake up.");

  property p_analog;
    @(posedge ref_clk_in) disable iff (rst_in)
    analog_en_r |-> din == 16'hffff ##1 pad_oe_n_out == 16'hffff;
  endproperty
  a_analog: assert property (p_analog)
    else $error("Analog use left a digital driver or input active.");

endmodule
`default_nettype wire

// [rtl/pef_pkg.sv]
// Constants, register map and types of the port edge interrupt block.
// Assumes a single 100 MHz bus clock and a plain strobe register port.
// What this block does
// - Sixteen edge interrupt pins, requests ORed together.
// - Per pin enable and edge select by software.
// - All pins drive one shared interrupt output.
// - Works for outputs and enabled digital inputs.
// - Request while any pending and enabled pair.
// - Qualified interrupt wakes from stop and wait.
// - Per pin filter drops too short pulses.
// - Four passive then four active samples needed.
// - Run and wait: filters sample every bus clock.
// - Stop: local oscillator paces the filter samples.
// - Oscillator runs while an enabled idle pin counts.
// - Stop mode still yields wake up requests.
// - Select bit zero falling, one rising edge.
// - Analog enabled: input reads one, output off.
package pef_pkg;

  // Port geometry and register bus widths.
  localparam int NPINS = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [7:0] OFS_IRQ_EN = 8'h00;
  localparam logic [7:0] OFS_POL = 8'h04;
  localparam logic [7:0] OFS_PEND = 8'h08;
  localparam logic [7:0] OFS_DIEN = 8'h0c;
  localparam logic [7:0] OFS_DIR = 8'h10;
  localparam logic [7:0] OFS_DOUT = 8'h14;
  localparam logic [7:0] OFS_PIN = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1c;
  localparam logic [7:0] OFS_MASK = 8'h20;
  localparam logic [7:0] OFS_ANA = 8'h24;

  // Event status layout, shared by the status and mask registers.
  localparam int STAT_W = 2;
  localparam int STAT_EDGE_BIT = 0;
  localparam int STAT_WAKE_BIT = 1;

  // Reset values.
  localparam logic [15:0] RST_PINS = 16'h0000;
  localparam logic [1:0] RST_STAT = 2'h0;
  localparam logic RST_ANA = 1'b0;

  // Filter run lengths and the oscillator keep alive limit.
  localparam logic [2:0] FLT_RUN_LEN = 3'h4;
  localparam logic [2:0] FLT_RUN_LAST = FLT_RUN_LEN - 3'h1;
  localparam logic [2:0] RC_CNT_LIMIT = 3'h4;

  // Stop mode sample period, emulated from the bus clock.
  localparam int CLK_PERIOD_NS = 10;
  localparam int RC_PERIOD_NS = 2500;
  localparam int RC_DIV = (RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RC_DIV_LAST = 8'(RC_DIV - 1);

  // Power mode as seen by the sample clock selection.
  typedef enum logic [1:0] {PEF_RUN, PEF_WAIT, PEF_STOP} pef_mode_t;

endpackage

// [rtl/pef_filt_if.sv]
// Bundle between the port top and one pin filter.
// Assumes both ends share the bus clock.
`timescale 1ns/1ps
`default_nettype none
interface pef_filt_if;
  logic sample;
  logic act;
  logic clr;
  logic edge_p;
  logic [2:0] count;
  modport src (output sample, output act, output clr,
               input edge_p, input count);
  modport flt (input sample, input act, input clr,
               output edge_p, output count);
endinterface
`default_nettype wire

// [rtl/pef_pin_filter.sv]
// One pin glitch filter: counts passive then active samples.
// Assumes the level is already turned so that one is the active level.
`timescale 1ns/1ps
`default_nettype none
module pef_pin_filter
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Filter bundle.
  pef_filt_if.flt f
);

  logic [2:0] pass_cnt_r;
  logic [2:0] act_cnt_r;
  logic edge_r;

  // Run counters; an active run counts only after a full passive run.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pass_cnt_r <= 3'h0;
      act_cnt_r <= 3'h0;
    end
    else if (f.clr)
    begin
      pass_cnt_r <= 3'h0;
      act_cnt_r <= 3'h0;
    end
    else if (f.sample)
    begin
      if (!f.act)
      begin
        act_cnt_r <= 3'h0;
        if (pass_cnt_r != pef_pkg::FLT_RUN_LEN)
          pass_cnt_r <= pass_cnt_r + 3'h1;
      end
      else if (pass_cnt_r == pef_pkg::FLT_RUN_LEN &&
               act_cnt_r != pef_pkg::FLT_RUN_LAST)
        act_cnt_r <= act_cnt_r + 3'h1;
      else
      begin
        // A finished edge or a broken passive run starts over.
        pass_cnt_r <= 3'h0;
        act_cnt_r <= 3'h0;
      end
    end
  end

  // One cycle edge pulse on the fourth active sample.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      edge_r <= 1'b0;
    else
      edge_r <= !f.clr && f.sample && f.act &&
                pass_cnt_r == pef_pkg::FLT_RUN_LEN &&
                act_cnt_r == pef_pkg::FLT_RUN_LAST;
  end

  assign f.edge_p = edge_r;
  assign f.count = act_cnt_r;

  // Steps of a clean and of a short pulse at full sample rate.
  sequence s_passive4;
    (f.sample && !f.act && !f.clr) [*4];
  endsequence
  sequence s_active4;
    (f.sample && f.act && !f.clr) [*4];
  endsequence
  sequence s_active3_drop;
    (f.sample && f.act && !f.clr) [*3] ##1 (f.sample && !f.act);
  endsequence

  property p_valid_edge;
    @(posedge clk_in) disable iff (rst_in)
    s_passive4 ##1 s_active4 |=> f.edge_p;
  endproperty
  a_valid_edge: assert property (p_valid_edge)
    else $error("Clean edge was not reported.");

  property p_short_pulse;
    @(posedge clk_in) disable iff (rst_in)
    s_passive4 ##1 s_active3_drop |=> !f.edge_p;
  endproperty
  a_short_pulse: assert property (p_short_pulse)
    else $error("Short pulse was reported as an edge.");

endmodule
`default_nettype wire

// [dv/pef_pad_model.sv]
// Far side of the port: external drivers on the sixteen pins.
// Assumes the bench sets the external levels just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module pef_pad_model
(
  // Pin side of the block.
  input wire logic [15:0] pad_drv_in,
  input wire logic [15:0] pad_oe_n_in,
  // Bench side.
  input wire logic [15:0] ext_level_in,
  output logic [15:0] pad_level_out
);
  // A driven pin reads back the block's own value, so edges on outputs
  // reach the filters; the outside driver is weaker and never fights it.
  assign pad_level_out = (pad_oe_n_in & ext_level_in) |
                         (~pad_oe_n_in & pad_drv_in);
endmodule
`default_nettype wire

// [dv/pef_port_edge_irq_test.sv]
// Self-checking bench for the sixteen pin edge interrupt port.
// Assumes the pad model closes the loop from pad outputs to pad inputs.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR %0t compare got %h exp %h", $time, got, exp); end end
module pef_port_edge_irq_test;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stop_m = 1'b0;
  logic wait_m = 1'b0;
  logic [15:0] ext = 16'h0000;
  logic [31:0] rdata;
  logic [15:0] pad_lvl;
  logic [15:0] pad_o;
  logic [15:0] pad_oe_n;
  logic port_irq;
  logic irq;
  logic wake;
  logic rc_run;
  int n_mismatch = 0;
  int checked = 0;

  // Bus clock at 100 MHz.
  always #5 ref_clk_in = ~ref_clk_in;

  pef_port_edge_irq u_dut
  (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .reg_addr_in(addr),
    .reg_wdata_in(wdata),
    .reg_wr_in(wr),
    .reg_rd_in(rd),
    .reg_rdata_out(rdata),
    .stop_mode_in(stop_m),
    .wait_mode_in(wait_m),
    .pad_in(pad_lvl),
    .pad_out(pad_o),
    .pad_oe_n_out(pad_oe_n),
    .port_irq_out(port_irq),
    .irq_out(irq),
    .wake_out(wake),
    .rc_run_out(rc_run)
  );

  pef_pad_model u_pads
  (
    .pad_drv_in(pad_o),
    .pad_oe_n_in(pad_oe_n),
    .ext_level_in(ext),
    .pad_level_out(pad_lvl)
  );

  // Verdict and end of run; also the exit of any wait that times out.
  task automatic print_verdict();
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Returns just after the edge so that outputs are settled when read.
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  // One write cycle; the strobe drops at the edge that takes it.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic set_ext(input logic [15:0] v);
    @(posedge ref_clk_in);
    ext <= v;
  endtask

  // Bounded wait on port_irq (0), wake (1) or the oscillator run (2).
  task automatic wait_for(input int sel, input logic lvl, input int lim);
    logic s;
    for (int i = 0; i < lim; i++)
    begin
      @(posedge ref_clk_in);
      #1;
      s = (sel == 0) ? port_irq : (sel == 1) ? wake : rc_run;
      if (s === lvl)
        return;
    end
    n_mismatch++;
    $display("ERROR %0t wait timed out", $time);
    print_verdict();
  endtask

  // Quiet state after reset, and an unmapped offset reading zero.
  task automatic t_reset();
    logic [31:0] d;
    `CHK(pad_oe_n, 16'hffff)
    `CHK(port_irq, 1'b0)
    rd_reg(pef_pkg::OFS_IRQ_EN, d);
    `CHK(d, 32'h0)
    rd_reg(8'h40, d);
    `CHK(d, 32'h0)
  endtask

  // Rising edge on pin 0; too early a request means the run was short.
  task automatic t_rise();
    logic [31:0] d;
    wr_reg(pef_pkg::OFS_DIEN, 32'h1);
    wr_reg(pef_pkg::OFS_POL, 32'h1);
    wr_reg(pef_pkg::OFS_MASK, 32'h1);
    wr_reg(pef_pkg::OFS_IRQ_EN, 32'h1);
    cycles(10);
    set_ext(16'h0001);
    cycles(5);
    `CHK(port_irq, 1'b0)
    wait_for(0, 1'b1, 20);
    `CHK(irq, 1'b1)
    rd_reg(pef_pkg::OFS_PEND, d);
    `CHK(d, 32'h1)
    rd_reg(pef_pkg::OFS_STAT, d);
    `CHK(d[0], 1'b1)
    rd_reg(pef_pkg::OFS_STAT, d);
    `CHK(d[0], 1'b0)
    `CHK(irq, 1'b0)
  endtask

  // A zero write keeps the flag; a one write clears it.
  task automatic t_w1c();
    logic [31:0] d;
    wr_reg(pef_pkg::OFS_PEND, 32'h0);
    cycles(2);
    `CHK(port_irq, 1'b1)
    wr_reg(pef_pkg::OFS_PEND, 32'h1);
    wait_for(0, 1'b0, 3);
    rd_reg(pef_pkg::OFS_PEND, d);
    `CHK(d, 32'h0)
  endtask

  // Falling edge on pin 5 after a three cycle glitch; pin 6 is disabled.
  task automatic t_glitch();
    logic [31:0] d;
    set_ext(16'h0061);
    wr_reg(pef_pkg::OFS_DIEN, 32'h0061);
    wr_reg(pef_pkg::OFS_IRQ_EN, 32'h0021);
    cycles(10);
    set_ext(16'h0001);
    cycles(2);
    set_ext(16'h0061);
    cycles(20);
    `CHK(port_irq, 1'b0)
    set_ext(16'h0001);
    wait_for(0, 1'b1, 20);
    rd_reg(pef_pkg::OFS_PEND, d);
    `CHK(d, 32'h20)
    wr_reg(pef_pkg::OFS_PEND, 32'h20);
    set_ext(16'h0061);
  endtask

  // Pin 3 as an output makes its own edge; analog mode takes the pins.
  task automatic t_output();
    logic [31:0] d;
    wr_reg(pef_pkg::OFS_DIR, 32'h8);
    wr_reg(pef_pkg::OFS_POL, 32'h9);
    wr_reg(pef_pkg::OFS_IRQ_EN, 32'h9);
    cycles(10);
    `CHK(pad_oe_n, 16'hfff7)
    wr_reg(pef_pkg::OFS_DOUT, 32'h8);
    wait_for(0, 1'b1, 20);
    `CHK(pad_o, 16'h0008)
    wr_reg(pef_pkg::OFS_PEND, 32'h8);
    wr_reg(pef_pkg::OFS_ANA, 32'h1);
    cycles(2);
    `CHK(pad_oe_n, 16'hffff)
    rd_reg(pef_pkg::OFS_PIN, d);
    `CHK(d[15:0], 16'hffff)
    wr_reg(pef_pkg::OFS_ANA, 32'h0);
    wr_reg(pef_pkg::OFS_IRQ_EN, 32'h0);
  endtask

  // In wait mode the bus clock still paces the filters.
  task automatic t_wait();
    logic [31:0] d;
    wr_reg(pef_pkg::OFS_DIEN, 32'h4);
    wr_reg(pef_pkg::OFS_POL, 32'h4);
    wr_reg(pef_pkg::OFS_IRQ_EN, 32'h4);
    @(posedge ref_clk_in);
    wait_m <= 1'b1;
    cycles(10);
    set_ext(16'h0065);
    wait_for(1, 1'b1, 20);
    wait_for(0, 1'b1, 3);
    rd_reg(pef_pkg::OFS_STAT, d);
    `CHK(d[1:0], 2'h3)
    wr_reg(pef_pkg::OFS_PEND, 32'h4);
    wait_for(1, 1'b0, 4);
    @(posedge ref_clk_in);
    wait_m <= 1'b0;
  endtask

  // Stop mode: slow oscillator samples, which stops once the flag is set.
  task automatic t_stop();
    wr_reg(pef_pkg::OFS_DIEN, 32'h2);
    wr_reg(pef_pkg::OFS_POL, 32'h2);
    wr_reg(pef_pkg::OFS_IRQ_EN, 32'h2);
    cycles(10);
    `CHK(rc_run, 1'b0)
    @(posedge ref_clk_in);
    stop_m <= 1'b1;
    wait_for(2, 1'b1, 5);
    set_ext(16'h0067);
    cycles(100);
    `CHK(port_irq, 1'b0)
    wait_for(1, 1'b1, 3000);
    wait_for(2, 1'b0, 5);
    @(posedge ref_clk_in);
    stop_m <= 1'b0;
    wr_reg(pef_pkg::OFS_PEND, 32'h2);
    wait_for(0, 1'b0, 4);
  endtask

  // Main sequence after a five cycle reset.
  initial
  begin
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_rise();
    t_w1c();
    t_glitch();
    t_output();
    t_wait();
    t_stop();
    print_verdict();
  end
endmodule
`default_nettype wire
